// [rtl/spd_consts.svh]
// Offsets, field positions, reset values and counts of the serial PLL divider core.
// Assumes nothing; included by every design file that needs these numbers.
`ifndef SPD_CONSTS_SVH
`define SPD_CONSTS_SVH

// Divider field widths.
`define SPD_A_W 6
`define SPD_N_W 12
`define SPD_R_W 14
`define SPD_PRESC_W 7

// Serial frame layout, oldest bit at the bottom of the shift register.
`define SPD_FRAME_W 20
`define SPD_SEL_HI_POS 19
`define SPD_SEL_LO_POS 18
`define SPD_A_LSB 0
`define SPD_N_LSB 6
`define SPD_R_LSB 4

// Selection codes as {select_bit_high, select_bit_low}.
`define SPD_SEL_FEEDBACK 2'h0
`define SPD_SEL_REFERENCE 2'h2

// Prescaler terminal counts: modulus 64 and 65, minus one.
`define SPD_PRESC_TOP_LOW 7'h3F
`define SPD_PRESC_TOP_HIGH 7'h40

// Divide values held after reset.
`define SPD_A_RESET 6'h00
`define SPD_N_RESET 12'h005
`define SPD_R_RESET 14'h0005

// Lock detector: widest error in clock cycles and comparisons needed in a row.
`define SPD_LOCK_WINDOW 4
`define SPD_LOCK_COUNT 3

`endif

// [rtl/spd_pkg.sv]
// Types of the serial PLL divider core.
// Assumes nothing of its surroundings.
package spd_pkg;

   // Three states of the phase-frequency comparator.
   typedef enum logic [1:0] {
      SPD_PFD_IDLE,
      SPD_PFD_UP,
      SPD_PFD_DOWN
   } spd_pfd_e;

   typedef logic [1:0] spd_select_t;

endpackage

// [rtl/spd_divider.sv]
// Loadable binary down counter used for the reference divider and the main counter.
// Assumes step_in is a one-cycle enable in the clk_in domain.
`timescale 1ns/1ps
`include "spd_consts.svh"

module spd_divider #(
   parameter int WIDTH = `SPD_N_W
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic reset_in,
   // Control.
   input wire logic restart_in,
   input wire logic step_in,
   input wire logic [WIDTH-1:0] reload_in,
   // Status.
   output logic [WIDTH-1:0] count_out,
   output logic terminal_out
);

   logic [WIDTH-1:0] count_q;

   // A count of zero is treated as one so that a prohibited value cannot stall the loop.
   assign terminal_out = step_in && (count_q <= WIDTH'(1));
   assign count_out = count_q;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         count_q <= '0;
      end else if (restart_in) begin
         count_q <= reload_in;
      end else if (step_in) begin
         if (count_q <= WIDTH'(1)) begin
            count_q <= reload_in;
         end else begin
            count_q <= count_q - WIDTH'(1);
         end
      end
   end

endmodule

// [rtl/spd_core.sv]
// Digital core of a serial-programmed PLL synthesizer: dividers, comparator, lock, power save.
// Assumes all pin inputs are synchronous to clk_in and slower than half its rate.
`timescale 1ns/1ps
`include "spd_consts.svh"

// Behaviour
// [RULE1] Active select high runs all logic; low stops dividers and comparator.
// [RULE2] Leaving power save realigns reference and feedback phase signals.
// [RULE3] In power save the charge pump output is high impedance.
// [RULE4] While active select is low, lock indicator is forced high.
// [RULE5] In active mode lock indicator is high when locked, low otherwise.
// [RULE6] Feedback divider: 64/65 prescaler, 6-bit swallow, 12-bit main counter.
// [RULE7] Divide by 65 for A main cycles, by 64 otherwise: 64N+A.
// [RULE8] Swallow accepts 0 to 63, main accepts 5 to 4095.
// [RULE9] Host keeps main count above swallow count.
// [RULE10] Reference divider is a 14-bit counter dividing by R, 5 to 16383.
// [RULE11] Pump high when reference leads, low when it lags; polarity select swaps.
// [RULE12] Each pump pulse lasts as long as the phase error.
// [RULE13] Serial data shifts in on serial clock; selection bits form the control register.
// [RULE14] Selection 00 targets feedback divider, low 0 high 1 targets reference.
// [RULE15] Feedback frame carries 18 divide bits, reference frame 14, plus two select bits.
// [RULE16] Load strobe AND selection enables only the chosen divider latch.
// [RULE17] Frames are 20 and 16 bits; extra bits leave only the latest effective.
// [RULE18] Loading one divider leaves the other divider unchanged.
// [RULE19] Divide values are plain binary, bit 0 least significant.
// [RULE20] Serial data is captured on each rising serial clock edge.
// [RULE21] On return to active both dividers restart together.
module spd_core #(
   parameter int LOCK_WINDOW = `SPD_LOCK_WINDOW,
   parameter int LOCK_COUNT = `SPD_LOCK_COUNT
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic reset_in,
   // Serial programming port.
   input wire logic serial_clk_in,
   input wire logic serial_data_in,
   input wire logic load_strobe_in,
   // Divider clock inputs.
   input wire logic rf_in,
   input wire logic ref_osc_input_in,
   // Mode pins.
   input wire logic active_select_in,
   input wire logic phase_polarity_select_in,
   // Charge pump, three-state: enable low while driving.
   output logic pump_out,
   output logic pump_oe_n_out,
   // Status.
   output logic lock_indicator_out,
   output logic ref_phase_signal_out,
   output logic feedback_phase_signal_out
);

   // ************************************************************
   // Edge detection
   // ************************************************************

   localparam int ERR_W = $clog2(LOCK_WINDOW + 2);
   localparam logic [ERR_W-1:0] ERR_MAX = ERR_W'(LOCK_WINDOW + 1);
   localparam logic [ERR_W-1:0] ERR_LIMIT = ERR_W'(LOCK_WINDOW);
   localparam int GOOD_W = $clog2(LOCK_COUNT + 1);
   localparam logic [GOOD_W-1:0] GOOD_MAX = GOOD_W'(LOCK_COUNT);
   logic serial_clk_q, rf_q, osc_q;
   logic serial_edge, rf_edge, osc_edge, restart;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         {serial_clk_q, rf_q, osc_q} <= 3'h0;
      end else begin
         {serial_clk_q, rf_q, osc_q} <= {serial_clk_in, rf_in, ref_osc_input_in};
      end
   end

   assign serial_edge = serial_clk_in && !serial_clk_q;
   assign rf_edge = rf_in && !rf_q;
   assign osc_edge = ref_osc_input_in && !osc_q;
   // Holding every counter at its start while saving power makes the wake-up aligned.
   assign restart = !active_select_in; // [RULE1] [RULE21]

   // ************************************************************
   // Serial shift register and divide latches
   // ************************************************************

   logic [`SPD_FRAME_W-1:0] shift_q;
   spd_pkg::spd_select_t select;
   logic [`SPD_A_W-1:0] swallow_val_q;
   logic [`SPD_N_W-1:0] main_val_q;
   logic [`SPD_R_W-1:0] ref_val_q;

   // New bits enter at the top, so the last frame always ends in the select bits.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         shift_q <= '0;
      end else if (serial_edge) begin
         shift_q <= {serial_data_in, shift_q[`SPD_FRAME_W-1:1]}; // [RULE13] [RULE17] [RULE20]
      end
   end

   assign select = {shift_q[`SPD_SEL_HI_POS], shift_q[`SPD_SEL_LO_POS]}; // [RULE13]

   // The selected latch is transparent while the strobe is high.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         swallow_val_q <= `SPD_A_RESET;
         main_val_q <= `SPD_N_RESET;
      end else if (load_strobe_in && select == `SPD_SEL_FEEDBACK) begin // [RULE14] [RULE16]
         swallow_val_q <= shift_q[`SPD_A_LSB +: `SPD_A_W]; // [RULE15] [RULE19] [RULE8]
         main_val_q <= shift_q[`SPD_N_LSB +: `SPD_N_W]; // [RULE15] [RULE19] [RULE8]
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         ref_val_q <= `SPD_R_RESET;
      end else if (load_strobe_in && select == `SPD_SEL_REFERENCE) begin // [RULE14] [RULE16]
         ref_val_q <= shift_q[`SPD_R_LSB +: `SPD_R_W]; // [RULE15] [RULE19] [RULE18]
      end
   end

   // ************************************************************
   // Dividers: prescaler, swallow, main and reference counters
   // ************************************************************

   logic [`SPD_PRESC_W-1:0] presc_q;
   logic [`SPD_A_W-1:0] swallow_q, swallow_d;
   logic [`SPD_N_W-1:0] main_count;
   logic presc_wrap, fb_pulse, ref_pulse;
   logic [`SPD_R_W-1:0] ref_count;

   // Modulus 65 while swallowing is still due, 64 afterwards.
   function automatic logic [`SPD_PRESC_W-1:0] presc_top(input logic [`SPD_A_W-1:0] left);
      return (left != '0) ? `SPD_PRESC_TOP_HIGH : `SPD_PRESC_TOP_LOW; // [RULE6] [RULE7]
   endfunction

   assign presc_wrap = rf_edge && active_select_in && presc_q == '0;

   always_comb begin
      swallow_d = swallow_q;
      if (fb_pulse) begin
         swallow_d = swallow_val_q;
      end else if (swallow_q != '0) begin
         swallow_d = swallow_q - `SPD_A_W'(1); // [RULE7]
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         presc_q <= `SPD_PRESC_TOP_LOW;
      end else if (restart) begin
         presc_q <= presc_top(swallow_val_q); // [RULE21]
      end else if (rf_edge) begin
         if (presc_q == '0) begin
            presc_q <= presc_top(swallow_d);
         end else begin
            presc_q <= presc_q - `SPD_PRESC_W'(1);
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         swallow_q <= `SPD_A_RESET;
      end else if (restart) begin
         swallow_q <= swallow_val_q;
      end else if (presc_wrap) begin
         swallow_q <= swallow_d; // [RULE7]
      end
   end

   spd_divider #(.WIDTH(`SPD_N_W)) main_counter (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .restart_in(restart),
      .step_in(presc_wrap),
      .reload_in(main_val_q),
      .count_out(main_count),
      .terminal_out(fb_pulse)
   ); // [RULE6]

   spd_divider #(.WIDTH(`SPD_R_W)) ref_counter (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .restart_in(restart),
      .step_in(osc_edge && active_select_in),
      .reload_in(ref_val_q),
      .count_out(ref_count),
      .terminal_out(ref_pulse)
   ); // [RULE10]

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         ref_phase_signal_out <= 1'b0;
         feedback_phase_signal_out <= 1'b0;
      end else begin
         ref_phase_signal_out <= ref_pulse;
         feedback_phase_signal_out <= fb_pulse;
      end
   end

   // ************************************************************
   // Phase comparator and charge pump
   // ************************************************************

   spd_pkg::spd_pfd_e pfd_q, pfd_d;

   always_comb begin
      pfd_d = pfd_q;
      case (pfd_q)
         spd_pkg::SPD_PFD_IDLE: begin
            if (ref_pulse && !fb_pulse) begin
               pfd_d = spd_pkg::SPD_PFD_UP;
            end else if (fb_pulse && !ref_pulse) begin
               pfd_d = spd_pkg::SPD_PFD_DOWN;
            end
         end
         spd_pkg::SPD_PFD_UP: begin
            if (fb_pulse) begin
               pfd_d = spd_pkg::SPD_PFD_IDLE; // [RULE12]
            end
         end
         spd_pkg::SPD_PFD_DOWN: begin
            if (ref_pulse) begin
               pfd_d = spd_pkg::SPD_PFD_IDLE; // [RULE12]
            end
         end
         default: begin
            pfd_d = spd_pkg::SPD_PFD_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (reset_in || restart) begin
         pfd_q <= spd_pkg::SPD_PFD_IDLE; // [RULE2]
      end else begin
         pfd_q <= pfd_d;
      end
   end

   // The pump trails the comparator by one cycle; pulse widths are unchanged.
   always_ff @(posedge clk_in) begin
      if (reset_in || restart || pfd_q == spd_pkg::SPD_PFD_IDLE) begin
         pump_out <= 1'b0;
         pump_oe_n_out <= 1'b1; // [RULE3]
      end else begin
         pump_out <= (pfd_q == spd_pkg::SPD_PFD_UP) ^ phase_polarity_select_in; // [RULE11]
         pump_oe_n_out <= 1'b0;
      end
   end

   // ************************************************************
   // Lock detector
   // ************************************************************

   logic [ERR_W-1:0] err_q;
   logic [GOOD_W-1:0] good_q;
   logic compare_ev, error_ok;

   assign compare_ev = (pfd_q != spd_pkg::SPD_PFD_IDLE && pfd_d == spd_pkg::SPD_PFD_IDLE)
      || (pfd_q == spd_pkg::SPD_PFD_IDLE && ref_pulse && fb_pulse);
   assign error_ok = (pfd_q == spd_pkg::SPD_PFD_IDLE) || (err_q < ERR_LIMIT);

   always_ff @(posedge clk_in) begin
      if (reset_in || restart || compare_ev) begin
         err_q <= '0;
      end else if (pfd_q != spd_pkg::SPD_PFD_IDLE && err_q != ERR_MAX) begin
         err_q <= err_q + ERR_W'(1);
      end
   end

   // A pulse that outgrows the window drops lock at once rather than at its end.
   always_ff @(posedge clk_in) begin
      if (reset_in || restart) begin
         good_q <= '0;
      end else if (compare_ev && error_ok) begin
         good_q <= (good_q == GOOD_MAX) ? GOOD_MAX : good_q + GOOD_W'(1);
      end else if (compare_ev || err_q == ERR_MAX) begin
         good_q <= '0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         lock_indicator_out <= 1'b0;
      end else begin
         lock_indicator_out <= restart || good_q == GOOD_MAX; // [RULE4] [RULE5]
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************

   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);

   sequence wake_s;
      !active_select_in ##1 active_select_in;
   endsequence

   lock_forced_a: assert property (!active_select_in |=> lock_indicator_out) // [RULE4]
      else $error("lock indicator not forced high in power save");
   lock_state_a: assert property (active_select_in && good_q != GOOD_MAX
      |=> !lock_indicator_out) // [RULE5]
      else $error("lock indicator high while unlocked");
   pump_save_a: assert property (!active_select_in |=> pump_oe_n_out) // [RULE3]
      else $error("charge pump driven in power save");
   pump_level_a: assert property (active_select_in && pfd_q == spd_pkg::SPD_PFD_UP
      |=> !pump_oe_n_out && pump_out == !$past(phase_polarity_select_in)) // [RULE11]
      else $error("wrong pump level for leading reference");
   pump_width_a: assert property (active_select_in && pfd_q == spd_pkg::SPD_PFD_IDLE
      |=> pump_oe_n_out) // [RULE12]
      else $error("pump driven with no phase error");
   wake_align_a: assert property (wake_s |-> main_count == main_val_q
      && ref_count == ref_val_q && swallow_q == swallow_val_q
      && pfd_q == spd_pkg::SPD_PFD_IDLE) // [RULE2] [RULE21]
      else $error("dividers not aligned on wake");
   swallow_mod_a: assert property (presc_wrap && !fb_pulse && swallow_q > `SPD_A_W'(1)
      |=> presc_q == `SPD_PRESC_TOP_HIGH) // [RULE7]
      else $error("prescaler not at modulus 65 while swallowing");
   fb_reload_a: assert property (fb_pulse && !restart
      |=> swallow_q == $past(swallow_val_q)) // [RULE7]
      else $error("swallow counter not reloaded at feedback edge");
   shift_in_a: assert property (serial_edge |=> shift_q[`SPD_FRAME_W-1] == $past(serial_data_in)
      && shift_q[`SPD_FRAME_W-2:0] == $past(shift_q[`SPD_FRAME_W-1:1])) // [RULE20]
      else $error("serial bit not captured");
   ref_load_a: assert property (load_strobe_in && select == `SPD_SEL_REFERENCE
      |=> ref_val_q == $past(shift_q[`SPD_R_LSB +: `SPD_R_W])
      && $stable(main_val_q) && $stable(swallow_val_q)) // [RULE16]
      else $error("reference load disturbed the feedback divider");

endmodule

// [verif/spd_host_model.sv]
// Host controller model that programs the divider core over the three-wire serial port.
// Assumes a free-running clk_in; frames are pushed by calling send from the testbench.
`timescale 1ns/1ps

module spd_host_model (
   // Clock.
   input wire logic clk_in,
   // Serial programming lines.
   output logic serial_clk_out,
   output logic serial_data_out,
   output logic load_strobe_out
);
   initial begin
      serial_clk_out = 1'b0;
      serial_data_out = 1'b0;
      load_strobe_out = 1'b0;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   // Sends 20 bits, bit 0 first, then pulses the strobe once.
   // Bits beyond a 16-bit frame go out first and end up in shift register bits 0 to 3, below the reference field.
   task automatic send(input logic [19:0] frame);
      step(1);
      for (int i = 0; i < 20; i++) begin
         serial_data_out = frame[i];
         step(2);
         serial_clk_out = 1'b1;
         step(2);
         serial_clk_out = 1'b0;
      end
      step(2);
      load_strobe_out = 1'b1;
      step(2);
      load_strobe_out = 1'b0;
      // The data line is no longer meaningful, so it shows the inverse of the last bit.
      serial_data_out = ~serial_data_out;
      step(2);
   endtask
endmodule

// [verif/spd_core_tb_top.sv]
// Self-checking testbench of the serial PLL divider core.
// Assumes the host model drives the serial port and one oscillator feeds both dividers.
`timescale 1ns/1ps

module spd_core_tb_top;
   // ***********************************************************************
   // Stimulus and observation
   // ***********************************************************************
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic active_select = 1'b0;
   logic polarity = 1'b0;
   logic [1:0] osc_q = 2'h0;
   logic serial_clk, serial_data, load_strobe;
   logic pump, pump_oe_n, lock, ref_pulse, fb_pulse;
   int failures = 0;
   int n_tests = 0;
   int cyc = 0;
   int n_ref = 0;
   int n_fb = 0;
   int n_hi = 0;
   int n_lo = 0;
   int tr, tf, tr0, tf0, snap;

   initial begin
      forever #5 clk_in = ~clk_in;
   end

   // Both divider inputs see the same edges, so equal ratios give coincident phases.
   always @(posedge clk_in) begin
      #1 osc_q <= osc_q + 2'h1;
   end

   always @(negedge clk_in) begin
      cyc = cyc + 1;
      n_ref = n_ref + (ref_pulse === 1'b1);
      n_fb = n_fb + (fb_pulse === 1'b1);
      if (pump_oe_n === 1'b0) begin
         if (pump === 1'b1) n_hi = n_hi + 1;
         else n_lo = n_lo + 1;
      end
   end

   spd_host_model u_spd_host_model (
      .clk_in(clk_in),
      .serial_clk_out(serial_clk),
      .serial_data_out(serial_data),
      .load_strobe_out(load_strobe)
   );

   spd_core u_spd_core (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .serial_clk_in(serial_clk),
      .serial_data_in(serial_data),
      .load_strobe_in(load_strobe),
      .rf_in(osc_q[1]),
      .ref_osc_input_in(osc_q[1]),
      .active_select_in(active_select),
      .phase_polarity_select_in(polarity),
      .pump_out(pump),
      .pump_oe_n_out(pump_oe_n),
      .lock_indicator_out(lock),
      .ref_phase_signal_out(ref_pulse),
      .feedback_phase_signal_out(fb_pulse)
   );

   // ***********************************************************************
   // Tasks
   // ***********************************************************************
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic check_bit(input logic act, input logic exp, input string what);
      n_tests++;
      if (act !== exp) begin
         failures++;
         $display("[FAIL] %0t %s: got %b expected %b", $time, what, act, exp);
      end
   endtask

   task automatic check_int(input int act, input int exp, input string what);
      n_tests++;
      if (act != exp) begin
         failures++;
         $display("[FAIL] %0t %s: got %0d expected %0d", $time, what, act, exp);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(negedge clk_in);
      #1;
   endtask

   task automatic drive_mode(input logic act, input logic pol);
      @(posedge clk_in);
      #1;
      active_select = act;
      polarity = pol;
   endtask

   // Waits for the next reference and feedback pulses and returns the cycle of each.
   task automatic wait_pair(output int t_ref, output int t_fb);
      int i;
      t_ref = -1;
      t_fb = -1;
      for (i = 0; i < 4000 && (t_ref < 0 || t_fb < 0); i++) begin
         settle(1);
         if (ref_pulse === 1'b1) t_ref = cyc;
         if (fb_pulse === 1'b1) t_fb = cyc;
      end
      if (t_ref < 0 || t_fb < 0) begin
         failures++;
         $display("[FAIL] %0t phase pulse wait timed out", $time);
         summarize();
      end
   endtask

   function automatic logic [19:0] ref_frame(input logic [13:0] r);
      return {2'b10, r, 4'h5};
   endfunction

   // ***********************************************************************
   // Sequence
   // ***********************************************************************
   initial begin
      repeat (12) @(posedge clk_in);
      #1;
      reset_in = 1'b0;
      settle(2);
      check_bit(pump_oe_n, 1'b1, "pump idle in save");
      check_bit(lock, 1'b1, "lock forced in save");
      // Reference ratio 322 matches feedback 64*5+2; a swallow count of 2 exercises modulus 65.
      u_spd_host_model.send(ref_frame(14'd322));
      u_spd_host_model.send({2'b00, 12'd5, 6'd2});
      u_spd_host_model.send({2'b01, 14'd100, 4'h0});
      drive_mode(1'b1, 1'b0);
      wait_pair(tr0, tf0);
      check_int(tr0, tf0, "phases aligned after wake");
      wait_pair(tr, tf);
      check_int(tr - tr0, 322 * 4, "reference period");
      check_int(tf - tf0, (64 * 5 + 2) * 4, "feedback period");
      wait_pair(tr, tf);
      wait_pair(tr, tf);
      settle(3);
      check_bit(lock, 1'b1, "lock with zero error");
      check_int(n_hi + n_lo, 0, "no pump drive when aligned");
      drive_mode(1'b0, 1'b0);
      settle(3);
      check_bit(pump_oe_n, 1'b1, "pump idle in save");
      check_bit(lock, 1'b1, "lock forced in save");
      snap = n_ref + n_fb;
      // Only the reference ratio changes; the feedback ratio must survive.
      u_spd_host_model.send(ref_frame(14'd323));
      settle(1500);
      check_int(n_ref + n_fb, snap, "dividers stopped in save");
      n_hi = 0;
      n_lo = 0;
      drive_mode(1'b1, 1'b0);
      wait_pair(tr, tf);
      check_int(tr - tf, 4, "reference lags by one input cycle");
      settle(4);
      check_int(n_lo, 4, "pump low width");
      check_int(n_hi, 0, "pump high width");
      wait_pair(tr, tf);
      wait_pair(tr, tf);
      settle(4);
      check_bit(lock, 1'b0, "unlock on wide error");
      drive_mode(1'b1, 1'b1);
      settle(2);
      n_hi = 0;
      n_lo = 0;
      wait_pair(tr, tf);
      settle(4);
      check_int(n_hi, 16, "swapped pump high width");
      check_int(n_lo, 0, "swapped pump low width");
      // A shorter reference ratio makes the reference lead by one input cycle.
      drive_mode(1'b0, 1'b0);
      settle(3);
      u_spd_host_model.send(ref_frame(14'd321));
      n_hi = 0;
      n_lo = 0;
      drive_mode(1'b1, 1'b0);
      wait_pair(tr, tf);
      check_int(tf - tr, 4, "reference leads by one input cycle");
      settle(4);
      check_int(n_hi, 4, "leading pump high width");
      check_int(n_lo, 0, "leading pump low width");
      summarize();
   end
endmodule
